//--- core/uart_regs_map.svh
`ifndef UART_REGS_MAP_SVH
`define UART_REGS_MAP_SVH

// ----------------------------------------
// register offsets, general set
// ----------------------------------------
`define OFS_HOLD 3'h0
`define OFS_IRQ_EN 3'h1
`define OFS_FIFO_CTL 3'h2
`define OFS_LINE_FMT 3'h3
`define OFS_MODEM 3'h4
`define OFS_LINE_STAT 3'h5
`define OFS_MODEM_STAT 3'h6
`define OFS_SCRATCH 3'h7

// ----------------------------------------
// offsets, divisor and enhanced sets
// ----------------------------------------
`define OFS_DIV_LOW 3'h0
`define OFS_DIV_HIGH 3'h1
`define OFS_ENH_FEAT 3'h2
`define OFS_ON_CHAR_1 3'h4
`define OFS_ON_CHAR_2 3'h5
`define OFS_OFF_CHAR_1 3'h6
`define OFS_OFF_CHAR_2 3'h7
`define OFS_HALT_LEVELS 3'h6
`define OFS_TRIG_LEVELS 3'h7
`define OFS_FIFO_READY 3'h7

// ----------------------------------------
// field positions and keys
// ----------------------------------------
`define ENH_KEY 8'hBF
`define DIV_ACCESS_BIT 7
`define ENH_ENABLE_BIT 4
`define MODEM_LEVELS_BIT 6
`define MODEM_RDY_BIT 2
`define MODEM_LOOP_BIT 4
`define FCR_ON_BIT 0
`define FCR_RX_RST_BIT 1
`define FCR_TX_RST_BIT 2
`define FCR_DMA_BIT 3
`define IID_NONE 4'h1

// ----------------------------------------
// reset values, depths, trigger counts
// ----------------------------------------
`define REG_RESET 8'h00
`define FIFO_DEPTH 64
`define RX_TRIG_0 7'h08
`define RX_TRIG_1 7'h10
`define RX_TRIG_2 7'h38
`define RX_TRIG_3 7'h3C
`define TX_TRIG_0 7'h08
`define TX_TRIG_1 7'h10
`define TX_TRIG_2 7'h20
`define TX_TRIG_3 7'h38
`define BIT_LAST_SUB 4'hF
`define BIT_MID_SUB 4'h7

`endif

//--- core/uart_pkg.sv
package uart_pkg;

  typedef struct packed {
    logic [7:0] lineFmt;
    logic [7:0] modemCtl;
    logic [7:0] irqEn;
    logic [7:0] enhFeat;
    logic [7:0] scratch;
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] onChar1;
    logic [7:0] onChar2;
    logic [7:0] offChar1;
    logic [7:0] offChar2;
    logic [7:0] haltLevels;
    logic [7:0] trigLevels;
    logic fifoOn;
    logic [1:0] rxTrigSel;
    logic [1:0] txTrigSel;
    logic dmaMode;
    logic rxRdyN;
    logic txRdyN;
  } chan_regs_t;

  typedef enum logic [3:0] {
    SH_IDLE = 4'b0001,
    SH_START = 4'b0010,
    SH_DATA = 4'b0100,
    SH_STOP = 4'b1000
  } shift_state_t;

endpackage

//--- core/fifo_if.sv
`timescale 1ns/1ns
interface fifo_if #(
  parameter int WIDTH = 8,
  parameter int AW = 6
);
  logic push;
  logic [WIDTH-1:0] pushData;
  logic pop;
  logic [WIDTH-1:0] popData;
  logic flush;
  logic single;
  logic [AW:0] count;
  logic full;
  logic empty;

  modport user(output push, pushData, pop, flush, single, input popData, count, full, empty);
  modport store(input push, pushData, pop, flush, single, output popData, count, full, empty);
endinterface

//--- core/byte_fifo.sv
`timescale 1ns/1ns
`include "uart_regs_map.svh"

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr, wrAddr;
  logic [AW:0] count, next_count;
  logic doPush, doPop;

  assign port.popData = mem[rdPtr];
  assign port.count = count;
  assign port.full = (count == (AW+1)'(DEPTH));
  assign port.empty = (count == '0);
  assign wrAddr = port.single ? '0 : wrPtr;

  always_comb begin
    doPop = port.pop & ~port.empty;
    doPush = port.push & (~port.full | doPop | port.single);
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (port.flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end else if (port.single && port.push) begin
      // one-deep mode: the newest character replaces the unread one
      next_rdPtr = '0;
      next_wrPtr = AW'(1);
      next_count = (AW+1)'(1);
    end else begin
      if (doPush) next_wrPtr = wrPtr + AW'(1);
      if (doPop) next_rdPtr = rdPtr + AW'(1);
      next_count = count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (doPush && !port.flush) begin
      mem[wrAddr] <= port.pushData;
    end
  end
endmodule

//--- core/serial_shifter.sv
`timescale 1ns/1ns
`include "uart_regs_map.svh"

module serial_shifter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] baudDivisor,
  input wire logic txLoad,
  input wire logic [7:0] txByte,
  input wire logic rxIn,
  output logic txOut,
  output logic txIdle,
  output logic rxValid,
  output logic [10:0] rxWord
);
  import uart_pkg::*;

  shift_state_t txState, next_txState, rxState, next_rxState;
  logic [15:0] divCnt, next_divCnt;
  logic [3:0] txSub, next_txSub, rxSub, next_rxSub;
  logic [2:0] txBit, next_txBit, rxBit, next_rxBit;
  logic [7:0] txShift, next_txShift, rxShift, next_rxShift;
  logic next_txOut, next_rxValid, tick;
  logic [10:0] next_rxWord;

  assign txIdle = (txState == SH_IDLE);

  always_comb begin
    tick = (divCnt == 16'h0000);
    next_divCnt = divCnt - 16'h0001;
    if (tick) next_divCnt = (baudDivisor == 16'h0000) ? 16'h0000 : baudDivisor - 16'h0001;
    next_txState = txState;
    next_txSub = txSub;
    next_txBit = txBit;
    next_txShift = txShift;
    next_rxState = rxState;
    next_rxSub = rxSub;
    next_rxBit = rxBit;
    next_rxShift = rxShift;
    next_rxValid = 1'b0;
    next_rxWord = rxWord;
    // ----------------------------------------
    // transmit: start, eight data, stop
    // ----------------------------------------
    case (txState)
      SH_IDLE: begin
        if (txLoad) begin
          next_txShift = txByte;
          next_txSub = 4'h0;
          next_txState = SH_START;
        end
      end
      SH_START, SH_DATA, SH_STOP: begin
        if (tick) next_txSub = txSub + 4'h1;
        if (tick && txSub == `BIT_LAST_SUB) begin
          if (txState == SH_START) begin
            next_txState = SH_DATA;
            next_txBit = 3'h0;
          end else if (txState == SH_DATA) begin
            next_txShift = {1'b0, txShift[7:1]};
            next_txBit = txBit + 3'h1;
            if (txBit == 3'h7) next_txState = SH_STOP;
          end else begin
            next_txState = SH_IDLE;
          end
        end
      end
      default: next_txState = SH_IDLE;
    endcase
    next_txOut = 1'b1;
    if (next_txState == SH_START) next_txOut = 1'b0;
    if (next_txState == SH_DATA) next_txOut = next_txShift[0];
    // ----------------------------------------
    // receive: sampled at mid bit
    // ----------------------------------------
    case (rxState)
      SH_IDLE: begin
        if (tick && !rxIn) begin
          next_rxSub = 4'h0;
          next_rxState = SH_START;
        end
      end
      SH_START: begin
        if (tick) next_rxSub = rxSub + 4'h1;
        if (tick && rxSub == `BIT_MID_SUB) begin
          next_rxSub = 4'h0;
          next_rxBit = 3'h0;
          next_rxState = rxIn ? SH_IDLE : SH_DATA;
        end
      end
      SH_DATA, SH_STOP: begin
        if (tick) next_rxSub = rxSub + 4'h1;
        if (tick && rxSub == `BIT_LAST_SUB) begin
          if (rxState == SH_DATA) begin
            next_rxShift = {rxIn, rxShift[7:1]};
            next_rxBit = rxBit + 3'h1;
            if (rxBit == 3'h7) next_rxState = SH_STOP;
          end else begin
            next_rxValid = 1'b1;
            next_rxWord = {~rxIn & (rxShift == 8'h00), ~rxIn, 1'b0, rxShift};
            next_rxState = SH_IDLE;
          end
        end
      end
      default: next_rxState = SH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt <= 16'h0000;
      txState <= SH_IDLE;
      rxState <= SH_IDLE;
      txSub <= 4'h0;
      rxSub <= 4'h0;
      txBit <= 3'h0;
      rxBit <= 3'h0;
      txShift <= 8'h00;
      rxShift <= 8'h00;
      txOut <= 1'b1;
      rxValid <= 1'b0;
      rxWord <= 11'h000;
    end else begin
      divCnt <= next_divCnt;
      txState <= next_txState;
      rxState <= next_rxState;
      txSub <= next_txSub;
      rxSub <= next_rxSub;
      txBit <= next_txBit;
      rxBit <= next_rxBit;
      txShift <= next_txShift;
      rxShift <= next_rxShift;
      txOut <= next_txOut;
      rxValid <= next_rxValid;
      rxWord <= next_rxWord;
    end
  end
endmodule

//--- core/uart_fifo_control_regmap.sv
`timescale 1ns/1ns
`include "uart_regs_map.svh"

module uart_fifo_control_regmap #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic chipSelA_n,
  input wire logic chipSelB_n,
  input wire logic [2:0] addr,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  input wire logic [1:0] serialRxIn,
  output logic [1:0] serialTxOut,
  output logic [1:0] rxReady_n,
  output logic [1:0] txReady_n
);
  import uart_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int SW = 11;

  // ----------------------------------------
  // bus strobes and read data
  // ----------------------------------------
  logic rdPrev, wrPrev, next_rdPrev, next_wrPrev;
  logic rdPulse, wrPulse, next_busDataOe;
  logic [7:0] next_busDataOut, fifoReady;
  logic [1:0] chanSel;
  logic [1:0][7:0] chanRead;

  assign chanSel = {~chipSelB_n, ~chipSelA_n};
  assign fifoReady = {2'b00, ~rxReady_n[1], ~rxReady_n[0],
                      2'b00, ~txReady_n[1], ~txReady_n[0]};

  always_comb begin
    next_rdPrev = readStrobe_n;
    next_wrPrev = writeStrobe_n;
    rdPulse = rdPrev & ~readStrobe_n;
    wrPulse = wrPrev & ~writeStrobe_n;
    next_busDataOe = ~readStrobe_n & (|chanSel);
    next_busDataOut = busDataOut;
    if (rdPulse) begin
      // channel A wins if both selects are low
      if (chanSel[0]) next_busDataOut = chanRead[0];
      else if (chanSel[1]) next_busDataOut = chanRead[1];
      else next_busDataOut = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdPrev <= 1'b1;
      wrPrev <= 1'b1;
      busDataOut <= 8'h00;
      busDataOe <= 1'b0;
    end else begin
      rdPrev <= next_rdPrev;
      wrPrev <= next_wrPrev;
      busDataOut <= next_busDataOut;
      busDataOe <= next_busDataOe;
    end
  end

  // ----------------------------------------
  // per-channel registers and FIFOs
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++) begin : chan
    chan_regs_t r, next_r;
    logic wrHit, rdHit, isKey, divAcc, enh, levelsOn, rdyOn;
    logic txIdle, txLoad, rxValid;
    logic [SW-1:0] rxWord;
    logic [7:0] rdVal, lineStat, intId, d;
    logic [AW:0] rxTrig, txTrig, txSpace;

    fifo_if #(.WIDTH(8), .AW(AW)) txQ();
    fifo_if #(.WIDTH(SW), .AW(AW)) rxQ();

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txStore (
      .mclk(mclk),
      .reset_n(reset_n),
      .port(txQ.store)
    );

    byte_fifo #(.WIDTH(SW), .DEPTH(DEPTH)) rxStore (
      .mclk(mclk),
      .reset_n(reset_n),
      .port(rxQ.store)
    );

    serial_shifter shifter (
      .mclk(mclk),
      .reset_n(reset_n),
      .baudDivisor({r.divHigh, r.divLow}),
      .txLoad(txLoad),
      .txByte(txQ.popData),
      .rxIn(serialRxIn[g]),
      .txOut(serialTxOut[g]),
      .txIdle(txIdle),
      .rxValid(rxValid),
      .rxWord(rxWord)
    );

    assign d = busDataIn;
    assign wrHit = wrPulse & chanSel[g];
    assign rdHit = rdPulse & chanSel[g];
    assign isKey = (r.lineFmt == `ENH_KEY);
    assign divAcc = r.lineFmt[`DIV_ACCESS_BIT];
    assign enh = r.enhFeat[`ENH_ENABLE_BIT];
    assign levelsOn = enh & r.modemCtl[`MODEM_LEVELS_BIT];
    assign rdyOn = r.modemCtl[`MODEM_RDY_BIT] & ~r.modemCtl[`MODEM_LOOP_BIT];
    // shifter takes the head byte as soon as it goes idle
    assign txLoad = txIdle & ~txQ.empty;
    assign txQ.pop = txLoad;
    assign txQ.single = 1'b0;
    assign rxQ.push = rxValid;
    assign rxQ.pushData = rxWord;
    assign rxQ.single = ~r.fifoOn;
    assign txSpace = (AW+1)'(DEPTH) - txQ.count;
    assign intId = {r.fifoOn, r.fifoOn, 2'b00, `IID_NONE};
    assign lineStat = {1'b0, txQ.empty & txIdle, txQ.empty,
                       rxQ.popData[10:8] & {3{~rxQ.empty}}, 1'b0, ~rxQ.empty};
    assign rxReady_n[g] = r.rxRdyN;
    assign txReady_n[g] = r.txRdyN;
    assign chanRead[g] = rdVal;

    always_comb begin
      case (r.rxTrigSel)
        2'b00: rxTrig = `RX_TRIG_0;
        2'b01: rxTrig = `RX_TRIG_1;
        2'b10: rxTrig = `RX_TRIG_2;
        default: rxTrig = `RX_TRIG_3;
      endcase
      case (r.txTrigSel)
        2'b00: txTrig = `TX_TRIG_0;
        2'b01: txTrig = `TX_TRIG_1;
        2'b10: txTrig = `TX_TRIG_2;
        default: txTrig = `TX_TRIG_3;
      endcase
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    always_comb begin
      rdVal = 8'h00;
      rxQ.pop = 1'b0;
      case (addr)
        `OFS_HOLD: begin
          if (divAcc) begin
            rdVal = r.divLow;
          end else begin
            rdVal = rxQ.popData[7:0];
            rxQ.pop = rdHit;
          end
        end
        `OFS_IRQ_EN: rdVal = divAcc ? r.divHigh : r.irqEn;
        `OFS_FIFO_CTL: begin
          if (isKey) rdVal = r.enhFeat;
          else if (!divAcc) rdVal = intId;
        end
        `OFS_LINE_FMT: rdVal = r.lineFmt;
        `OFS_MODEM: begin
          if (isKey) rdVal = r.onChar1;
          else if (!divAcc) rdVal = r.modemCtl;
        end
        `OFS_LINE_STAT: begin
          if (isKey) rdVal = r.onChar2;
          else if (!divAcc) rdVal = lineStat;
        end
        `OFS_MODEM_STAT: begin
          if (isKey) rdVal = r.offChar1;
          else if (!divAcc && levelsOn) rdVal = r.haltLevels;
        end
        default: begin
          if (isKey) rdVal = r.offChar2;
          else if (!divAcc && rdyOn) rdVal = fifoReady;
          else if (!divAcc && levelsOn) rdVal = r.trigLevels;
          else if (!divAcc) rdVal = r.scratch;
        end
      endcase
    end

    // ----------------------------------------
    // write decode and ready levels
    // ----------------------------------------
    always_comb begin
      next_r = r;
      txQ.push = 1'b0;
      txQ.pushData = d;
      txQ.flush = 1'b0;
      rxQ.flush = 1'b0;
      if (wrHit) begin
        case (addr)
          `OFS_HOLD: begin
            if (divAcc) next_r.divLow = d;
            else txQ.push = 1'b1;
          end
          `OFS_IRQ_EN: begin
            if (divAcc) next_r.divHigh = d;
            else next_r.irqEn = enh ? d : {r.irqEn[7:4], d[3:0]};
          end
          `OFS_FIFO_CTL: begin
            if (isKey) begin
              next_r.enhFeat = d;
            end else if (!divAcc) begin
              next_r.fifoOn = d[`FCR_ON_BIT];
              rxQ.flush = d[`FCR_RX_RST_BIT];
              txQ.flush = d[`FCR_TX_RST_BIT];
              next_r.dmaMode = d[`FCR_DMA_BIT];
              next_r.rxTrigSel = d[7:6];
              if (enh) next_r.txTrigSel = d[5:4];
            end
          end
          `OFS_LINE_FMT: next_r.lineFmt = d;
          `OFS_MODEM: begin
            if (isKey) next_r.onChar1 = d;
            else if (!divAcc) next_r.modemCtl = enh ? d : {r.modemCtl[7:5], d[4:0]};
          end
          `OFS_LINE_STAT: begin
            if (isKey) next_r.onChar2 = d;
          end
          `OFS_MODEM_STAT: begin
            if (isKey) next_r.offChar1 = d;
            else if (!divAcc && levelsOn) next_r.haltLevels = d;
          end
          default: begin
            if (isKey) next_r.offChar2 = d;
            else if (!divAcc && levelsOn) next_r.trigLevels = d;
            else if (!divAcc) next_r.scratch = d;
          end
        endcase
      end
      // mode 0, or mode 1 with fifos off, signals single characters; mode 1 with fifos on the trigger levels
      if (r.dmaMode && r.fifoOn) begin
        next_r.rxRdyN = ~(rxQ.count >= rxTrig);
        next_r.txRdyN = ~(txSpace >= txTrig);
      end else begin
        next_r.rxRdyN = rxQ.empty;
        next_r.txRdyN = ~txQ.empty;
      end
    end

    // ----------------------------------------
    // register state
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        // fifos off, divisor zero, receive ready inactive, transmit ready active
        r.lineFmt <= `REG_RESET;
        r.modemCtl <= `REG_RESET;
        r.irqEn <= `REG_RESET;
        r.enhFeat <= `REG_RESET;
        r.scratch <= `REG_RESET;
        r.divLow <= `REG_RESET;
        r.divHigh <= `REG_RESET;
        r.onChar1 <= `REG_RESET;
        r.onChar2 <= `REG_RESET;
        r.offChar1 <= `REG_RESET;
        r.offChar2 <= `REG_RESET;
        r.haltLevels <= `REG_RESET;
        r.trigLevels <= `REG_RESET;
        r.fifoOn <= 1'b0;
        r.rxTrigSel <= 2'b00;
        r.txTrigSel <= 2'b00;
        r.dmaMode <= 1'b0;
        r.rxRdyN <= 1'b1;
        r.txRdyN <= 1'b0;
      end else begin
        r <= next_r;
      end
    end
  end
endmodule

//--- bench/uart_regmap_sva.sv
`timescale 1ns/1ns
module uart_regmap_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic chipSelA_n,
  input wire logic chipSelB_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe,
  input wire logic [1:0] serialRxIn,
  input wire logic [1:0] serialTxOut,
  input wire logic [1:0] rxReady_n,
  input wire logic [1:0] txReady_n
);
  // ----------------------------------------
  // strobe edge and line age helpers
  // ----------------------------------------
  logic rdPrev;
  logic next_rdPrev;
  logic [7:0] rxAge;
  logic [7:0] next_rxAge;
  logic anySel;
  logic rdEdge;
  logic accA;
  logic wrA;
  assign anySel = !(chipSelA_n && chipSelB_n);
  assign rdEdge = !readStrobe_n && rdPrev && anySel;
  assign accA = !chipSelA_n && !(readStrobe_n && writeStrobe_n);
  assign wrA = !chipSelA_n && !writeStrobe_n;
  always_comb begin
    next_rdPrev = readStrobe_n;
    next_rxAge = (rxAge == 8'hFF) ? rxAge : rxAge + 8'h01;
    if (!serialRxIn[0]) begin
      next_rxAge = 8'h00;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdPrev <= 1'b1;
      rxAge <= 8'hFF;
    end else begin
      rdPrev <= next_rdPrev;
      rxAge <= next_rxAge;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_oe_follows_read: assert property (
    busDataOe == $past(!readStrobe_n && anySel)) else $error("read enable out of step");
  chk_read_data_holds: assert property (
    !$past(rdEdge) |-> $stable(busDataOut)) else $error("read data moved without read");
  chk_reset_values: assert property ($rose(reset_n) |-> !busDataOe &&
    busDataOut == 8'h00 && serialTxOut == 2'b11 && rxReady_n == 2'b11 && txReady_n == 2'b00)
    else $error("wrong output values out of reset");
  chk_txa_bit_len: assert property (
    $changed(serialTxOut[0]) |=> $stable(serialTxOut[0]) [*8]) else $error("short bit on A");
  chk_txb_bit_len: assert property (
    $changed(serialTxOut[1]) |=> $stable(serialTxOut[1]) [*8]) else $error("short bit on B");
  chk_rx_ready_drop: assert property ($rose(rxReady_n[0]) |->
    $past(accA) || $past(accA, 2) || $past(accA, 3) || $past(accA, 4))
    else $error("receive ready dropped without access");
  chk_tx_ready_drop: assert property ($rose(txReady_n[0]) |->
    $past(wrA) || $past(wrA, 2) || $past(wrA, 3) || $past(wrA, 4))
    else $error("transmit ready dropped without write");
  chk_rx_ready_cause: assert property (
    $fell(rxReady_n[0]) |-> rxAge < 8'hC8) else $error("receive ready without a frame");
endmodule

bind uart_fifo_control_regmap uart_regmap_sva sva (.mclk(mclk), .reset_n(reset_n),
  .chipSelA_n(chipSelA_n), .chipSelB_n(chipSelB_n), .readStrobe_n(readStrobe_n),
  .writeStrobe_n(writeStrobe_n), .busDataOut(busDataOut), .busDataOe(busDataOe),
  .serialRxIn(serialRxIn), .serialTxOut(serialTxOut), .rxReady_n(rxReady_n),
  .txReady_n(txReady_n));

//--- bench/serial_peer.sv
`timescale 1ns/1ns
module serial_peer (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine
);
  // ----------------------------------------
  // remote end: 8N1 frames both ways
  // ----------------------------------------
  int bitLen = 16;
  logic [7:0] got[$];
  logic [7:0] b;
  initial rxLine = 1'b1;
  task automatic send(input logic [7:0] d, input logic badStop);
    logic [9:0] f;
    f = {!badStop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxLine <= f[i];
      repeat (bitLen) @(negedge mclk);
    end
    rxLine <= 1'b1;
    repeat (bitLen) @(negedge mclk);
  endtask
  always begin
    @(negedge txLine);
    repeat (bitLen / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitLen) @(posedge mclk);
      b[i] = txLine;
    end
    repeat (bitLen) @(posedge mclk);
    got.push_back(b);
  end
endmodule

//--- bench/uart_fifo_control_regmap_tb.sv
`timescale 1ns/1ns
module uart_fifo_control_regmap_tb;
  // ----------------------------------------
  // bench signals, tasks and sequence
  // ----------------------------------------
  localparam logic [1:0] SA = 2'b10;
  localparam logic [1:0] SB = 2'b01;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] sel = 2'b11;
  logic [2:0] addr = 3'h0;
  logic rdStb_n = 1'b1;
  logic wrStb_n = 1'b1;
  logic [7:0] din = 8'h00;
  logic [7:0] dout;
  logic [7:0] rv;
  logic oe;
  logic [1:0] rxl;
  logic [1:0] txl;
  logic [1:0] rxRdyN;
  logic [1:0] txRdyN;
  int fails = 0;
  int cmp_count = 0;
  int trig[4] = '{8, 16, 56, 60};
  always #50 mclk = ~mclk;
  uart_fifo_control_regmap dut (.mclk(mclk), .reset_n(reset_n), .chipSelA_n(sel[0]),
    .chipSelB_n(sel[1]), .addr(addr), .readStrobe_n(rdStb_n), .writeStrobe_n(wrStb_n),
    .busDataIn(din), .busDataOut(dout), .busDataOe(oe), .serialRxIn(rxl),
    .serialTxOut(txl), .rxReady_n(rxRdyN), .txReady_n(txRdyN));
  serial_peer peerA (.mclk(mclk), .txLine(txl[0]), .rxLine(rxl[0]));
  serial_peer peerB (.mclk(mclk), .txLine(txl[1]), .rxLine(rxl[1]));
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic f, input logic e);
    check({7'h00, f}, {7'h00, e});
  endtask
  task automatic acc(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d,
                     input logic w);
    @(negedge mclk);
    sel = s;
    addr = a;
    din = d;
    rdStb_n = w;
    wrStb_n = !w;
    repeat (2) @(negedge mclk);
    rv = dout;
    rdStb_n = 1'b1;
    wrStb_n = 1'b1;
    sel = 2'b11;
  endtask
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    acc(s, a, d, 1'b1);
  endtask
  task automatic rd(input logic [1:0] s, input logic [2:0] a, input logic [7:0] e);
    acc(s, a, 8'h00, 1'b0);
    check(rv, e);
  endtask
  task automatic waitGot(input int n);
    for (int i = 0; i < 60000 && peerA.got.size() < n; i++) @(negedge mclk);
  endtask
  initial begin
    #9_000_000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    check({rxRdyN, txRdyN, 3'h0, oe}, 8'hC0);
    wr(SA, 3'h7, 8'h55);
    wr(SB, 3'h7, 8'hAA);
    rd(SA, 3'h7, 8'h55);
    rd(SB, 3'h7, 8'hAA);
    rd(SA, 3'h2, 8'h01);
    wr(SA, 3'h4, 8'h40);
    rd(SA, 3'h4, 8'h00);
    wr(SA, 3'h3, 8'h80);
    wr(SA, 3'h0, 8'h34);
    wr(SA, 3'h1, 8'h12);
    wr(SA, 3'h7, 8'hFF);
    rd(SA, 3'h0, 8'h34);
    rd(SA, 3'h1, 8'h12);
    rd(SA, 3'h2, 8'h00);
    rd(SA, 3'h7, 8'h00);
    wr(SA, 3'h0, 8'h04);
    wr(SA, 3'h1, 8'h00);
    wr(SA, 3'h3, 8'h00);
    rd(SA, 3'h7, 8'h55);
    peerA.bitLen = 64;
    for (int i = 0; i < 66; i++) wr(SA, 3'h0, 8'(i));
    waitGot(65);
    repeat (800) @(negedge mclk);
    check(8'(peerA.got.size()), 8'h41);
    check(peerA.got[64], 8'h40);
    peerA.got.delete();
    wr(SA, 3'h2, 8'h39);
    for (int i = 0; i < 10; i++) wr(SA, 3'h0, 8'(8'h10 + i));
    flag(txRdyN[0], 1'b0);
    rd(SA, 3'h2, 8'hC1);
    wr(SA, 3'h2, 8'h3D);
    waitGot(1);
    check(peerA.got[0], 8'h10);
    peerA.got.delete();
    wr(SA, 3'h3, 8'hBF);
    wr(SA, 3'h2, 8'h95);
    for (int i = 4; i < 8; i++) wr(SA, 3'(i), 8'(8'h40 + i));
    for (int i = 4; i < 8; i++) rd(SA, 3'(i), 8'(8'h40 + i));
    rd(SA, 3'h2, 8'h95);
    wr(SA, 3'h3, 8'h80);
    rd(SA, 3'h4, 8'h00);
    wr(SA, 3'h0, 8'h00);
    wr(SA, 3'h3, 8'h00);
    peerA.bitLen = 16;
    wr(SA, 3'h4, 8'h40);
    rd(SA, 3'h4, 8'h40);
    wr(SA, 3'h6, 8'h3C);
    wr(SA, 3'h7, 8'h66);
    rd(SA, 3'h6, 8'h3C);
    rd(SA, 3'h7, 8'h66);
    wr(SA, 3'h4, 8'h00);
    rd(SA, 3'h6, 8'h00);
    rd(SA, 3'h7, 8'h55);
    wr(SA, 3'h2, 8'h39);
    for (int i = 0; i < 10; i++) wr(SA, 3'h0, 8'(8'h20 + i));
    flag(txRdyN[0], 1'b1);
    wr(SA, 3'h2, 8'h3D);
    repeat (3) @(negedge mclk);
    flag(txRdyN[0], 1'b0);
    wr(SA, 3'h2, 8'h31);
    wr(SA, 3'h0, 8'h77);
    flag(txRdyN[0], 1'b1);
    wr(SA, 3'h2, 8'h35);
    waitGot(1);
    repeat (400) @(negedge mclk);
    check(8'(peerA.got.size()), 8'h01);
    check(peerA.got[0], 8'h20);
    for (int t = 0; t < 4; t++) begin
      wr(SA, 3'h2, {2'(t), 6'h3B});
      for (int k = 1; k < trig[t]; k++) peerA.send(8'(k), 1'b0);
      repeat (4) @(negedge mclk);
      flag(rxRdyN[0], 1'b1);
      peerA.send(8'hEE, 1'b0);
      repeat (4) @(negedge mclk);
      flag(rxRdyN[0], 1'b0);
    end
    wr(SA, 3'h2, 8'h02);
    peerA.send(8'h61, 1'b0);
    peerA.send(8'h62, 1'b0);
    rd(SA, 3'h0, 8'h62);
    flag(rxRdyN[0], 1'b1);
    wr(SA, 3'h2, 8'h01);
    peerA.send(8'h33, 1'b0);
    peerA.send(8'h5A, 1'b1);
    acc(SA, 3'h5, 8'h00, 1'b0);
    check(rv & 8'h09, 8'h01);
    rd(SA, 3'h0, 8'h33);
    acc(SA, 3'h5, 8'h00, 1'b0);
    check(rv & 8'h09, 8'h09);
    rd(SA, 3'h0, 8'h5A);
    peerB.send(8'h42, 1'b0);
    repeat (4) @(negedge mclk);
    flag(rxRdyN[1], 1'b0);
    wr(SA, 3'h4, 8'h04);
    rd(SA, 3'h7, 8'h23);
    wr(SA, 3'h4, 8'h14);
    rd(SA, 3'h7, 8'h55);
    rd(SB, 3'h0, 8'h42);
    wr(SB, 3'h0, 8'hC3);
    repeat (200) @(negedge mclk);
    check(peerB.got[0], 8'hC3);
    complete_run();
  end
endmodule
